// *** hw/tpw_consts.vh ***
`ifndef TPW_CONSTS_VH
`define TPW_CONSTS_VH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define TPW_CLK_NS 4
`define TPW_MS_NS 1000000
`define TPW_MS_CYCLES (`TPW_MS_NS / `TPW_CLK_NS)
// Sample period in ns is update setting * SAMPLE_NUM_NS / SAMPLE_SCALE
`define TPW_SAMPLE_NUM_NS 1000000
`define TPW_SAMPLE_SCALE 1024
`define TPW_UPDATE_DEFAULT 16'd1000

// ----------------------------------------
// Wait opcodes
// ----------------------------------------
`define TPW_OPW 4
`define TPW_OP_MOTION_COMPLETE 4'h0
`define TPW_OP_REL_DISTANCE 4'h1
`define TPW_OP_REPEAT_DISTANCE 4'h2
`define TPW_OP_ABS_POSITION 4'h3
`define TPW_OP_FWD_CROSSING 4'h4
`define TPW_OP_REV_CROSSING 4'h5
`define TPW_OP_IN_POSITION 4'h6
`define TPW_OP_INPUT_LEVEL 4'h7
`define TPW_OP_SLEW_SPEED 4'h8
`define TPW_OP_REF_TIME 4'h9
`define TPW_OP_DELAY 4'ha
`define TPW_OP_PATH_DISTANCE 4'hb

// ----------------------------------------
// Codes and field sizes
// ----------------------------------------
`define TPW_STOP_TIMEOUT 8'h63
`define TPW_AXW 3
`define TPW_POSW 32
`define TPW_UNIT_MS 1'b0
`define TPW_UNIT_SAMPLE 1'b1

`endif

// *** hw/tpw_tick_gen.v ***
`include "tpw_consts.vh"

// ----------------------------------------
// Servo sample and millisecond ticks
// ----------------------------------------
module tpw_tick_gen #(
    parameter MS_CYCLES = `TPW_MS_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Update-rate setting
    input wire [15:0] servo_update_period,
    // Ticks
    output reg smp_tick,
    output reg ms_tick
);

localparam [39:0] STEP = `TPW_CLK_NS * `TPW_SAMPLE_SCALE;
localparam [39:0] NUM = `TPW_SAMPLE_NUM_NS;
localparam [31:0] MS_LAST = MS_CYCLES - 1;

wire [39:0] thresh = {24'h0, servo_update_period} * NUM;
wire [39:0] acc_sum;
reg [39:0] acc_q;
reg [31:0] ms_cnt_q;

assign acc_sum = acc_q + STEP;

// Fractional accumulator keeps the mean sample period exact
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        acc_q <= 40'h0;
        smp_tick <= 1'b0;
        ms_cnt_q <= 32'h0;
        ms_tick <= 1'b0;
    end else begin
        if (acc_sum >= thresh) begin // R18
            acc_q <= acc_sum - thresh;
            smp_tick <= 1'b1;
        end else begin
            acc_q <= acc_sum;
            smp_tick <= 1'b0;
        end
        if (ms_cnt_q >= MS_LAST) begin
            ms_cnt_q <= 32'h0;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
            ms_tick <= 1'b0;
        end
    end
end

endmodule // tpw_tick_gen

// *** hw/tpw_trippoint_wait_unit.v ***
// Summary of operation
// [R1] A decoded wait stalls the sequencer until its condition holds.
// [R2] Motion-complete wait releases when all named axes finish; no operand means all.
// [R3] Relative-distance wait trips when commanded position moved n from move start.
// [R4] Repeat-distance wait trips n beyond the last repeat or relative trip point.
// [R5] Absolute-position wait trips when the axis reaches the given position.
// [R6] Forward-crossing wait trips at position going forward; immediate if already beyond.
// [R7] Reverse-crossing wait trips at position going backward; immediate if already past.
// [R8] In-position wait needs profile done and encoder at or past target.
// [R9] In-position timeout clears hold, sets stop code 99, diverts to handler.
// [R10] Input-level wait: positive operand high, negative low; line range checked.
// [R11] Slew-speed wait releases once every named axis is at slew speed.
// [R12] Reference-time: 0 latches reference, n waits, -n waits then advances reference.
// [R13] Delay wait holds for the operand time from decode.
// [R14] Unit selector 0 counts milliseconds, 1 counts servo samples.
// [R15] Path-distance wait releases when the vector path covered the distance.
// [R16] A relative move while the axis moves is refused with an error.
// [R17] Position trippoints are evaluated once per servo sample.
// [R18] Sample period is derived from the update-rate setting.
// [R19] One pending trippoint; release in the sample its condition becomes true.
// [R20] Position waits need exactly one axis, else command error without holding.
`include "tpw_consts.vh"

module tpw_trippoint_wait_unit #(
    parameter AXES = 8,
    parameter NUM_INPUTS = 48,
    parameter MS_CYCLES = `TPW_MS_CYCLES
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Sequencer command
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire [AXES:0] cmd_axes,
    input wire [31:0] cmd_operand,
    input wire cmd_unit,
    // Sequencer answer
    output reg seq_hold_q,
    output reg seq_release_q,
    output reg cmd_error_q,
    output reg timeout_jump_q,
    // Stop code report
    output reg stop_code_wr_q,
    output reg [2:0] stop_code_axis_q,
    output reg [7:0] stop_code_q,
    // Relative move request
    input wire rel_move_valid,
    input wire [2:0] rel_move_axis,
    output reg rel_move_ack_q,
    output reg rel_move_err_q,
    // Axis state
    input wire [AXES*32-1:0] axis_cmd_pos,
    input wire [AXES*32-1:0] axis_enc_pos,
    input wire [AXES*32-1:0] axis_start_pos,
    input wire [AXES-1:0] axis_moving,
    input wire [AXES-1:0] axis_at_slew,
    input wire [AXES*32-1:0] in_position_timeout,
    input wire seq_moving,
    input wire seq_at_slew,
    input wire [31:0] path_dist,
    // Pins and setting
    input wire [NUM_INPUTS-1:0] in_lines,
    input wire [15:0] servo_update_period
);

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_HOLD = 2'd1;

// ----------------------------------------
// Helpers
// ----------------------------------------
function [31:0] pick;
    input [AXES*32-1:0] v;
    input [2:0] i;
    integer k;
    begin
        pick = 32'h0;
        for (k = 0; k < AXES; k = k + 1) begin
            if ({29'h0, i} == k) begin
                pick = v[k*32 +: 32];
            end
        end
    end
endfunction

function [3:0] ones;
    input [AXES:0] m;
    integer k;
    begin
        ones = 4'h0;
        for (k = 0; k <= AXES; k = k + 1) begin
            ones = ones + {3'h0, m[k]};
        end
    end
endfunction

function [2:0] first_idx;
    input [AXES:0] m;
    integer k;
    begin
        first_idx = 3'h0;
        for (k = AXES - 1; k >= 0; k = k - 1) begin
            if (m[k]) begin
                first_idx = k[2:0];
            end
        end
    end
endfunction

// ----------------------------------------
// Ticks and input synchroniser
// ----------------------------------------
wire smp_tick;
wire ms_tick;

tpw_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .servo_update_period(servo_update_period),
    .smp_tick(smp_tick),
    .ms_tick(ms_tick)
);

reg [NUM_INPUTS-1:0] in_meta_q;
reg [NUM_INPUTS-1:0] in_sync_q;

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        in_meta_q <= {NUM_INPUTS{1'b0}};
        in_sync_q <= {NUM_INPUTS{1'b0}};
    end else begin
        in_meta_q <= in_lines;
        in_sync_q <= in_meta_q;
    end
end

// ----------------------------------------
// State
// ----------------------------------------
reg [1:0] state_q;
reg [3:0] op_q;
reg [2:0] ax_q;
reg [AXES:0] mask_q;
reg [31:0] target_q;
reg dir_q;
reg lvl_q;
reg [5:0] line_q;
reg unit_q;
reg [31:0] tbase_q;
reg [31:0] tlen_q;
reg adv_q;
reg [31:0] to_base_q;
reg [31:0] ms_now_q;
reg [31:0] smp_now_q;
reg [31:0] ref_ms_q;
reg [31:0] ref_smp_q;
reg [31:0] rpt_base [0:AXES-1];

// ----------------------------------------
// Issue-time decode
// ----------------------------------------
wire [31:0] n_mag = cmd_operand[31] ? (~cmd_operand + 32'h1) : cmd_operand;
wire [2:0] c_ax = first_idx(cmd_axes);
wire [31:0] c_cmd = pick(axis_cmd_pos, c_ax);
wire [31:0] c_start = pick(axis_start_pos, c_ax);
wire [31:0] c_rpt = rpt_base[c_ax];
wire [31:0] now_unit = cmd_unit ? smp_now_q : ms_now_q;
wire [31:0] ref_unit = cmd_unit ? ref_smp_q : ref_ms_q;
wire c_single = (ones(cmd_axes) == 4'h1) && !cmd_axes[AXES];
wire c_posop = (cmd_op == `TPW_OP_REL_DISTANCE) || (cmd_op == `TPW_OP_REPEAT_DISTANCE) ||
    (cmd_op == `TPW_OP_ABS_POSITION) || (cmd_op == `TPW_OP_FWD_CROSSING) ||
    (cmd_op == `TPW_OP_REV_CROSSING) || (cmd_op == `TPW_OP_IN_POSITION);
wire c_badline = (n_mag == 32'h0) || (n_mag > NUM_INPUTS);
wire c_err = (c_posop && !c_single) || // R20
    ((cmd_op == `TPW_OP_INPUT_LEVEL) && c_badline) || // R10
    (cmd_op > `TPW_OP_PATH_DISTANCE);

// ----------------------------------------
// Hold-time conditions
// ----------------------------------------
wire [31:0] h_cmd = pick(axis_cmd_pos, ax_q);
wire [31:0] h_enc = pick(axis_enc_pos, ax_q);
wire [31:0] h_tw = pick(in_position_timeout, ax_q);
wire h_moving = axis_moving[ax_q];
wire cmd_hit = dir_q ? ($signed(h_cmd) >= $signed(target_q)) : ($signed(h_cmd) <= $signed(target_q));
wire enc_hit = dir_q ? ($signed(h_enc) >= $signed(target_q)) : ($signed(h_enc) <= $signed(target_q));
wire enc_in = dir_q ? ($signed(h_enc) >= $signed(h_cmd)) : ($signed(h_enc) <= $signed(h_cmd));
wire [AXES:0] busy_vec = {seq_moving, axis_moving};
wire [AXES:0] slew_vec = {seq_at_slew, axis_at_slew};
wire [31:0] t_now = unit_q ? smp_now_q : ms_now_q;
wire [31:0] t_el = t_now - tbase_q;
wire [31:0] to_el = ms_now_q - to_base_q;
wire timed_out = (op_q == `TPW_OP_IN_POSITION) && (h_tw != 32'h0) && (to_el >= h_tw);
reg cond;
reg per_sample;

always @* begin
    cond = 1'b0;
    per_sample = 1'b1;
    case (op_q)
        `TPW_OP_MOTION_COMPLETE: cond = ((busy_vec & mask_q) == {(AXES+1){1'b0}}); // R2
        `TPW_OP_REL_DISTANCE: cond = cmd_hit; // R3
        `TPW_OP_REPEAT_DISTANCE: cond = cmd_hit; // R4
        `TPW_OP_ABS_POSITION: cond = cmd_hit; // R5
        `TPW_OP_FWD_CROSSING: cond = enc_hit; // R6
        `TPW_OP_REV_CROSSING: cond = enc_hit; // R7
        `TPW_OP_IN_POSITION: cond = !h_moving && enc_in; // R8
        `TPW_OP_SLEW_SPEED: cond = ((slew_vec & mask_q) == mask_q); // R11
        `TPW_OP_PATH_DISTANCE: cond = ($signed(path_dist) >= $signed(target_q)); // R15
        `TPW_OP_INPUT_LEVEL: begin
            cond = (in_sync_q[line_q] == lvl_q); // R10
            per_sample = 1'b0;
        end
        `TPW_OP_REF_TIME, `TPW_OP_DELAY: begin
            cond = (t_el >= tlen_q); // R12 R13
            per_sample = 1'b0;
        end
        default: begin
            cond = 1'b1;
            per_sample = 1'b0;
        end
    endcase
end

// Position-type waits only look on a sample boundary
wire trip = cond && (!per_sample || smp_tick); // R17 R19

// ----------------------------------------
// Sequencer hold control
// ----------------------------------------
integer i;

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        state_q <= ST_IDLE;
        op_q <= `TPW_OP_MOTION_COMPLETE;
        ax_q <= 3'h0;
        mask_q <= {(AXES+1){1'b0}};
        target_q <= 32'h0;
        dir_q <= 1'b0;
        lvl_q <= 1'b0;
        line_q <= 6'h0;
        unit_q <= `TPW_UNIT_MS;
        tbase_q <= 32'h0;
        tlen_q <= 32'h0;
        adv_q <= 1'b0;
        to_base_q <= 32'h0;
        ms_now_q <= 32'h0;
        smp_now_q <= 32'h0;
        ref_ms_q <= 32'h0;
        ref_smp_q <= 32'h0;
        seq_hold_q <= 1'b0;
        seq_release_q <= 1'b0;
        cmd_error_q <= 1'b0;
        timeout_jump_q <= 1'b0;
        stop_code_wr_q <= 1'b0;
        stop_code_axis_q <= 3'h0;
        stop_code_q <= 8'h0;
        rel_move_ack_q <= 1'b0;
        rel_move_err_q <= 1'b0;
        for (i = 0; i < AXES; i = i + 1) begin
            rpt_base[i] <= 32'h0;
        end
    end else begin
        seq_release_q <= 1'b0;
        cmd_error_q <= 1'b0;
        timeout_jump_q <= 1'b0;
        stop_code_wr_q <= 1'b0;
        rel_move_ack_q <= rel_move_valid && !axis_moving[rel_move_axis];
        rel_move_err_q <= rel_move_valid && axis_moving[rel_move_axis]; // R16
        if (ms_tick) begin
            ms_now_q <= ms_now_q + 32'h1;
        end
        if (smp_tick) begin
            smp_now_q <= smp_now_q + 32'h1;
        end
        case (state_q)
            ST_IDLE: begin
                if (cmd_valid) begin
                    op_q <= cmd_op;
                    ax_q <= c_ax;
                    mask_q <= (cmd_axes == {(AXES+1){1'b0}}) ? {(AXES+1){1'b1}} : cmd_axes; // R2
                    unit_q <= cmd_unit; // R14
                    lvl_q <= !cmd_operand[31];
                    line_q <= n_mag[5:0] - 6'h1;
                    tlen_q <= n_mag;
                    adv_q <= cmd_operand[31];
                    to_base_q <= ms_now_q;
                    target_q <= cmd_operand;
                    dir_q <= 1'b1;
                    case (cmd_op)
                        `TPW_OP_REL_DISTANCE: begin
                            target_q <= c_start + cmd_operand; // R3
                            dir_q <= !cmd_operand[31];
                        end
                        `TPW_OP_REPEAT_DISTANCE: begin
                            target_q <= c_rpt + cmd_operand; // R4
                            dir_q <= !cmd_operand[31];
                        end
                        `TPW_OP_ABS_POSITION: dir_q <= ($signed(cmd_operand) >= $signed(c_cmd)); // R5
                        `TPW_OP_REV_CROSSING: dir_q <= 1'b0; // R7
                        `TPW_OP_IN_POSITION: dir_q <= ($signed(c_cmd) >= $signed(c_start));
                        `TPW_OP_REF_TIME: tbase_q <= ref_unit; // R12
                        `TPW_OP_DELAY: tbase_q <= now_unit; // R13
                        default: dir_q <= 1'b1;
                    endcase
                    if (c_err) begin
                        cmd_error_q <= 1'b1; // R20
                    end else if (cmd_op == `TPW_OP_REF_TIME && cmd_operand == 32'h0) begin
                        ref_ms_q <= ms_now_q; // R12
                        ref_smp_q <= smp_now_q;
                        seq_release_q <= 1'b1;
                    end else begin
                        seq_hold_q <= 1'b1; // R1
                        state_q <= ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (timed_out && !trip) begin
                    seq_hold_q <= 1'b0; // R9
                    timeout_jump_q <= 1'b1;
                    stop_code_wr_q <= 1'b1;
                    stop_code_axis_q <= ax_q;
                    stop_code_q <= `TPW_STOP_TIMEOUT;
                    state_q <= ST_IDLE;
                end else if (trip) begin
                    seq_hold_q <= 1'b0; // R1 R19
                    seq_release_q <= 1'b1;
                    state_q <= ST_IDLE;
                    if (op_q == `TPW_OP_REL_DISTANCE || op_q == `TPW_OP_REPEAT_DISTANCE) begin
                        rpt_base[ax_q] <= target_q; // R4
                    end
                    if (op_q == `TPW_OP_REF_TIME && adv_q) begin
                        if (unit_q) begin
                            ref_smp_q <= ref_smp_q + tlen_q; // R12
                        end else begin
                            ref_ms_q <= ref_ms_q + tlen_q;
                        end
                    end
                end
            end
            default: begin
                state_q <= ST_IDLE;
                seq_hold_q <= 1'b0;
            end
        endcase
    end
end

endmodule // tpw_trippoint_wait_unit

// *** verification/tpw_axis_model.sv ***
// ----
// Axis profilers, encoders and path
// ----
module tpw_axis_model #(
    parameter int AXES = 8,
    parameter int SPD = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Move request
    input wire logic go,
    input wire logic [2:0] go_axis,
    input wire logic [31:0] go_dist,
    // Axis state
    output logic [AXES*32-1:0] cmd_pos,
    output logic [AXES*32-1:0] enc_pos,
    output logic [AXES*32-1:0] start_pos,
    output logic [AXES-1:0] moving,
    output logic [AXES-1:0] at_slew,
    output logic seq_moving,
    output logic seq_at_slew,
    output logic [31:0] path
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [31:0] tgt [AXES];
    function automatic logic signed [31:0] gap(input int k);
        return tgt[k] - $signed(cmd_pos[k*32+:32]);
    endfunction
    assign seq_moving = |moving;
    assign seq_at_slew = |at_slew;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_pos <= '0;
            enc_pos <= '0;
            start_pos <= '0;
            moving <= '0;
            at_slew <= '0;
            path <= '0;
            for (int k = 0; k < AXES; k++) tgt[k] <= '0;
        end else begin
            // Encoder trails command by one cycle
            enc_pos <= cmd_pos;
            for (int k = 0; k < AXES; k++) begin
                if (moving[k]) begin
                    at_slew[k] <= 1'b1;
                    path <= path + SPD;
                    if (gap(k) > SPD) cmd_pos[k*32+:32] <= cmd_pos[k*32+:32] + SPD;
                    else if (gap(k) < -SPD) cmd_pos[k*32+:32] <= cmd_pos[k*32+:32] - SPD;
                    else begin
                        cmd_pos[k*32+:32] <= tgt[k];
                        moving[k] <= 1'b0;
                        at_slew[k] <= 1'b0;
                    end
                end
            end
            if (go) begin
                start_pos[go_axis*32+:32] <= cmd_pos[go_axis*32+:32];
                tgt[go_axis] <= $signed(cmd_pos[go_axis*32+:32]) + $signed(go_dist);
                moving[go_axis] <= 1'b1;
                path <= '0;
            end
        end
    end
endmodule // tpw_axis_model

// *** verification/tpw_trippoint_wait_unit_monitor.sv ***
module tpw_trippoint_wait_unit_monitor #(
    parameter int AXES = 8,
    parameter int NUM_INPUTS = 48
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Sequencer
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [AXES:0] cmd_axes,
    input wire logic [31:0] cmd_operand,
    input wire logic seq_hold_q,
    input wire logic seq_release_q,
    input wire logic cmd_error_q,
    input wire logic timeout_jump_q,
    input wire logic stop_code_wr_q,
    input wire logic [7:0] stop_code_q,
    // Moves, axes, pins
    input wire logic rel_move_valid,
    input wire logic [2:0] rel_move_axis,
    input wire logic rel_move_ack_q,
    input wire logic rel_move_err_q,
    input wire logic [AXES-1:0] axis_moving,
    input wire logic [31:0] path_dist,
    input wire logic [NUM_INPUTS-1:0] in_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] op_q;
    logic [AXES:0] ax_q;
    logic [31:0] n_q;
    logic [31:0] ln;
    logic take, bad_pos, lvl_ok;
    assign take = cmd_valid && !seq_hold_q;
    assign bad_pos = cmd_op >= 4'h1 && cmd_op <= 4'h6 && (cmd_axes[AXES] || $countones(cmd_axes) != 1);
    assign ln = n_q[31] ? -n_q : n_q;
    assign lvl_ok = ln >= 1 && ln <= NUM_INPUTS && in_lines[ln-1] == !n_q[31];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_q <= '0;
            ax_q <= '0;
            n_q <= '0;
        end else if (take) begin
            op_q <= cmd_op;
            ax_q <= cmd_axes;
            n_q <= cmd_operand;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_level;
        (seq_hold_q && op_q == 4'h7 && lvl_ok)[*3];
    endsequence
    property p_refuse; take && bad_pos |=> cmd_error_q && !seq_hold_q; endproperty
    property p_rel_err; rel_move_valid && axis_moving[rel_move_axis] |=> rel_move_err_q && !rel_move_ack_q; endproperty
    property p_rel_ack; rel_move_valid && !axis_moving[rel_move_axis] |=> rel_move_ack_q && !rel_move_err_q; endproperty
    property p_fall; $fell(seq_hold_q) |-> seq_release_q || timeout_jump_q; endproperty
    property p_tmo; timeout_jump_q |-> stop_code_wr_q && stop_code_q == 8'h63 && !seq_hold_q; endproperty
    property p_all; seq_release_q && op_q == 4'h0 && ax_q == '0 |-> $past(axis_moving) == '0; endproperty
    property p_path; seq_release_q && op_q == 4'hb |-> $signed($past(path_dist)) >= $signed(n_q); endproperty
    property p_level; s_level |=> ##[0:2] seq_release_q; endproperty
    a_refuse: assert property (p_refuse) else $error("bad axis set not refused");
    a_rel_err: assert property (p_rel_err) else $error("move on moving axis not refused");
    a_rel_ack: assert property (p_rel_ack) else $error("move on idle axis not taken");
    a_fall: assert property (p_fall) else $error("hold dropped without release");
    a_tmo: assert property (p_tmo) else $error("timeout report wrong");
    a_all: assert property (p_all) else $error("released while an axis moves");
    a_path: assert property (p_path) else $error("path released short");
    a_level: assert property (p_level) else $error("input level hold not released");
endmodule // tpw_trippoint_wait_unit_monitor

bind tpw_trippoint_wait_unit tpw_trippoint_wait_unit_monitor #(.AXES(AXES), .NUM_INPUTS(NUM_INPUTS)) i_mon (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_axes(cmd_axes),
    .cmd_operand(cmd_operand), .seq_hold_q(seq_hold_q), .seq_release_q(seq_release_q),
    .cmd_error_q(cmd_error_q), .timeout_jump_q(timeout_jump_q), .stop_code_wr_q(stop_code_wr_q),
    .stop_code_q(stop_code_q), .rel_move_valid(rel_move_valid), .rel_move_axis(rel_move_axis),
    .rel_move_ack_q(rel_move_ack_q), .rel_move_err_q(rel_move_err_q), .axis_moving(axis_moving),
    .path_dist(path_dist), .in_lines(in_lines)
);

// *** verification/tpw_trippoint_wait_unit_test.sv ***
`include "tpw_consts.vh"

module tpw_trippoint_wait_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 25;
    logic ref_clk = 0, rst = 1, cmd_valid = 0, cmd_unit = 0, rel_move_valid = 0, go = 0;
    logic [3:0] cmd_op = '0;
    logic [8:0] cmd_axes = '0;
    logic [31:0] cmd_operand = '0, go_dist = '0, pdist, ln;
    logic [2:0] rel_move_axis = '0, go_axis = '0, sca;
    logic [47:0] in_lines = '0;
    logic [15:0] upd = 16'h0001;
    logic [255:0] tmo = '0, cpos, epos, spos;
    logic [7:0] mov, slew, sc;
    logic smov, sslew, hold, rel, err, tj, scw, ack, rerr, neg;
    int err_count = 0, tests_run = 0, seed = 17, cyc;
    always #2 ref_clk = ~ref_clk;

    tpw_trippoint_wait_unit #(.MS_CYCLES(MSC)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_axes(cmd_axes),
        .cmd_operand(cmd_operand), .cmd_unit(cmd_unit), .seq_hold_q(hold), .seq_release_q(rel),
        .cmd_error_q(err), .timeout_jump_q(tj), .stop_code_wr_q(scw), .stop_code_axis_q(sca),
        .stop_code_q(sc), .rel_move_valid(rel_move_valid), .rel_move_axis(rel_move_axis),
        .rel_move_ack_q(ack), .rel_move_err_q(rerr), .axis_cmd_pos(cpos), .axis_enc_pos(epos),
        .axis_start_pos(spos), .axis_moving(mov), .axis_at_slew(slew), .in_position_timeout(tmo),
        .seq_moving(smov), .seq_at_slew(sslew), .path_dist(pdist), .in_lines(in_lines),
        .servo_update_period(upd));
    tpw_axis_model i_axes (.ref_clk(ref_clk), .rst(rst), .go(go), .go_axis(go_axis), .go_dist(go_dist),
        .cmd_pos(cpos), .enc_pos(epos), .start_pos(spos), .moving(mov), .at_slew(slew),
        .seq_moving(smov), .seq_at_slew(sslew), .path(pdist));

    task automatic chkb(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wcmd(input logic [3:0] op, input logic [8:0] ax, input logic [31:0] n, input logic u);
        @(posedge ref_clk) #1;
        cmd_valid = 1;
        cmd_op = op;
        cmd_axes = ax;
        cmd_operand = n;
        cmd_unit = u;
        @(posedge ref_clk) #1;
        cmd_valid = 0;
        cyc = 0;
        while (!(rel || err || tj) && cyc < 5000) begin
            @(posedge ref_clk) #1;
            cyc++;
        end
        chkb(cyc < 5000, 1);
    endtask
    task automatic move(input logic [2:0] a, input logic [31:0] d);
        @(posedge ref_clk) #1;
        go = 1;
        go_axis = a;
        go_dist = d;
        @(posedge ref_clk) #1;
        go = 0;
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        summarize;
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 0;
        for (int i = 0; i < 4; i++) begin
            wcmd(4'h1 + 4'($unsigned($random(seed)) % 6), i == 0 ? 9'h003 : i == 1 ? 9'h101 : 9'h000, 0, 0);
            chkb(err, 1);
            chkb(hold, 0);
        end
        $display("refusals done");
        move(0, 4000);
        rel_move_valid = 1;
        @(posedge ref_clk) #1;
        chkb(rerr, 1);
        rel_move_axis = 1;
        @(posedge ref_clk) #1;
        chkb(ack, 1);
        rel_move_valid = 0;
        wcmd(4'h0, 0, 0, 0);
        chkb(rel, 1);
        chkv(32'(mov), 0);
        wcmd(4'h6, 9'h001, 0, 0);
        chkb(rel, 1);
        wcmd(4'h4, 9'h001, 1000, 0);
        chkb(cyc < 250, 1);
        wcmd(4'h5, 9'h001, 9000, 0);
        chkb(cyc < 250, 1);
        move(0, 2000);
        wcmd(4'h4, 9'h001, 5000, 0);
        chkb($signed(epos[31:0]) >= 5000 && $signed(epos[31:0]) <= 7500, 1);
        move(1, 3000);
        wcmd(4'hb, 0, 1500, 0);
        chkb(rel, 1);
        move(2, 30000);
        wcmd(4'h1, 9'h004, 1000, 0);
        chkb($signed(cpos[95:64]) >= 1000 && $signed(cpos[95:64]) <= 3600, 1);
        wcmd(4'h2, 9'h004, 5000, 0);
        chkb($signed(cpos[95:64]) >= 6000 && $signed(cpos[95:64]) <= 8600, 1);
        wcmd(4'h3, 9'h004, 12000, 0);
        chkb($signed(cpos[95:64]) >= 12000 && $signed(cpos[95:64]) <= 14600, 1);
        wcmd(4'h8, 9'h004, 0, 0);
        chkb(rel && cyc < 250, 1);
        $display("motion waits done");
        wcmd(4'ha, 0, 2, 0);
        chkb(cyc >= MSC && cyc <= 2 * MSC + 3, 1);
        wcmd(4'ha, 0, 2, 1);
        chkb(cyc >= 240 && cyc <= 495, 1);
        wcmd(4'h9, 0, 0, 0);
        chkb(rel && cyc < 2, 1);
        wcmd(4'h9, 0, -3, 0);
        chkb(rel, 1);
        wcmd(4'h9, 0, 3, 0);
        chkb(cyc >= 2 * MSC && cyc <= 3 * MSC + 5, 1);
        $display("timed waits done");
        for (int i = 0; i < 3; i++) begin
            ln = 32'($unsigned($random(seed)) % 48) + 1;
            neg = 1'($random(seed));
            in_lines = neg ? '1 : '0;
            fork
                wcmd(4'h7, 0, neg ? -ln : ln, 0);
                begin
                    repeat (30) @(posedge ref_clk);
                    #1 chkb(hold, 1);
                    in_lines[ln-1] = !neg;
                end
            join
            chkb(rel && cyc >= 29, 1);
        end
        wcmd(4'h7, 0, 49, 0);
        chkb(err, 1);
        $display("input waits done");
        tmo[31:0] = 2;
        move(0, 100000);
        wcmd(4'h6, 9'h001, 0, 0);
        chkb(tj, 1);
        chkb(scw, 1);
        chkv(32'(sc), 32'(`TPW_STOP_TIMEOUT));
        chkv(32'(sca), 0);
        $display("timeout done");
        summarize;
    end
endmodule // tpw_trippoint_wait_unit_test
